// File: src/ebc_pkg.sv
// ebc_pkg: constants and types shared by the external bus cycle block
// assumes: one 20 MHz clock, synchronous active-high reset
package ebc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned HOLD_MAX_NS     = 800;  // 4 bus cycles without waits
  localparam int unsigned HOLD_MAX_CYC    = HOLD_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam int unsigned STRAP_DELAY_CYC = 1;    // strap caught on the fourth clock after release, one beyond the sync stages

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [19:0] ADDR_RST = 20'h00000;

  // ---------------------------------------------------------------
  // cycle kinds requested by the core
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EBC_KIND_MEM,
    EBC_KIND_IO,
    EBC_KIND_INTA,
    EBC_KIND_RFSH
  } ebc_kind_type;

  // bus cycle states; tw is the wait state between t3 and t4
  typedef enum logic [2:0] {
    EBC_IDLE,
    EBC_T1,
    EBC_T2,
    EBC_T3,
    EBC_TW,
    EBC_T4,
    EBC_HOLD
  } ebc_state_type;

endpackage

// File: src/ebc_sync.sv
// ebc_sync: two-flop synchroniser for a level from outside the clock domain
// assumes: input is asynchronous to clk_i; output lags by two edges
`timescale 1ns/1ps
module ebc_sync
  import ebc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_ff;

  // first flop feeds only the second flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_o  <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end
endmodule

// File: src/ebc_strap.sv
// ebc_strap: catches the address-enable strap after reset release
// assumes: strap_i already synchronised; pull-up lives on the pad
`timescale 1ns/1ps
module ebc_strap
  import ebc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic strap_i,
  output logic      addr_en_n_o,
  output logic      done_o
);
  logic [1:0] cnt_ff;

  // count edges after release, latch strap once; wait out the sync stages first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff      <= 2'h0;
      addr_en_n_o <= 1'b1;
      done_o      <= 1'b0;
    end else if (!done_o) begin
      cnt_ff <= cnt_ff + 2'h1;
      if (cnt_ff == 2'(STRAP_DELAY_CYC + SYNC_STAGES)) begin
        addr_en_n_o <= strap_i;
        done_o      <= 1'b1;
      end
    end
  end
endmodule

// File: src/ebc_top.sv
// ebc_top: external local-bus cycle sequencer with bus hold handshake
// assumes: core offers one request at a time and drops it after t1 entry, before done_o;
// pads resolve each three-signal pin from its output enable
`timescale 1ns/1ps

module ebc_top
  import ebc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // core side
  input  wire logic         req_i,
  input  wire ebc_kind_type kind_i,
  input  wire logic         write_i,
  input  wire logic [19:0]  addr_i,
  input  wire logic [1:0]   lanes_i,      // bit1 high byte, bit0 low byte
  input  wire logic [15:0]  wdata_i,
  input  wire logic         low_region_i, // cycle hits low region select
  input  wire logic         up_region_i,  // cycle hits upper region select
  input  wire logic         low_region_select_config_disable_address_bit_i,
  input  wire logic         upper_region_select_config_disable_address_bit_i,
  input  wire logic         narrow_bus_i, // 8-bit variant
  input  wire logic         chip_sel_n_i, // decoded selects, low active
  output logic              done_o,
  output logic [15:0]       rdata_o,
  // pins
  input  wire logic         async_ready_i,
  input  wire logic         sync_ready_i,
  input  wire logic         hold_req_i,
  input  wire logic         addr_enable_strap_n_i,
  input  wire logic [15:0]  muxed_addr_data_bus_i,
  output logic [15:0]       muxed_addr_data_bus_o,
  output logic [15:0]       muxed_addr_data_bus_oe_o,
  output logic [7:0]        high_address_outputs_o,
  output logic              high_address_outputs_oe_o,
  output logic [19:0]       nonmuxed_address_bus_o,
  output logic              nonmuxed_address_bus_oe_o,
  output logic              addr_strobe_o,
  output logic              byte_high_en_n_o,
  output logic              byte_high_en_oe_o,
  output logic              wr_high_n_o,
  output logic              wr_low_n_o,
  output logic              wr_strobe_oe_o,
  output logic              xcvr_en_n_o,
  output logic              xcvr_en_oe_o,
  output logic              transfer_direction_o,
  output logic              transfer_direction_oe_o,
  output logic              chip_sel_n_o,
  output logic              hold_ack_o
);
  // ---------------------------------------------------------------
  // synchronisers and strap
  // ---------------------------------------------------------------
  logic ardy_s, srdy_s, hold_s, strap_s, strap_n, strap_done;

  ebc_sync u_ardy  (.clk_i(clk_i), .rst_i(rst_i), .async_i(async_ready_i),
                    .sync_o(ardy_s));
  ebc_sync u_srdy  (.clk_i(clk_i), .rst_i(rst_i), .async_i(sync_ready_i),
                    .sync_o(srdy_s));
  ebc_sync u_hold  (.clk_i(clk_i), .rst_i(rst_i), .async_i(hold_req_i),
                    .sync_o(hold_s));
  ebc_sync u_strap (.clk_i(clk_i), .rst_i(rst_i), .async_i(addr_enable_strap_n_i),
                    .sync_o(strap_s));
  ebc_strap u_cap  (.clk_i(clk_i), .rst_i(rst_i), .strap_i(strap_s),
                    .addr_en_n_o(strap_n), .done_o(strap_done));

  // ---------------------------------------------------------------
  // state and latched cycle
  // ---------------------------------------------------------------
  ebc_state_type state_ff, nxt_state;
  ebc_kind_type  kind_ff;
  logic          write_ff;
  logic [19:0]   addr_ff;
  logic [1:0]    lanes_ff;
  logic [15:0]   wdata_ff;
  logic          addr_on_bus_ff;
  logic          narrow_ff;
  logic          dir_ff;
  logic          ready;

  // ready: async high wins, else sync ready
  assign ready = ardy_s | srdy_s;

  // next-state: refresh outranks hold, hold outranks other cycles
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      EBC_IDLE: begin
        if (req_i && kind_i == EBC_KIND_RFSH && strap_done) begin
          nxt_state = EBC_T1;
        end else if (hold_s) begin
          nxt_state = EBC_HOLD;
        end else if (req_i && strap_done) begin
          nxt_state = EBC_T1;
        end
      end
      EBC_T1: nxt_state = EBC_T2;
      EBC_T2: nxt_state = EBC_T3;
      EBC_T3: nxt_state = ready ? EBC_T4 : EBC_TW;
      EBC_TW: nxt_state = ready ? EBC_T4 : EBC_TW;
      EBC_T4: nxt_state = EBC_IDLE;
      EBC_HOLD: begin
        // release on drop, or reclaim for a pending refresh
        if (!hold_s || (req_i && kind_i == EBC_KIND_RFSH)) begin
          nxt_state = EBC_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= EBC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latch the request at t1 entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_ff        <= EBC_KIND_MEM;
      write_ff       <= 1'b0;
      addr_ff        <= ADDR_RST;
      lanes_ff       <= 2'h0;
      wdata_ff       <= DATA_RST;
      addr_on_bus_ff <= 1'b1;
      narrow_ff      <= 1'b0;
    end else if (state_ff == EBC_IDLE && nxt_state == EBC_T1) begin
      kind_ff   <= kind_i;
      write_ff  <= write_i && kind_i != EBC_KIND_RFSH;
      addr_ff   <= addr_i;
      lanes_ff  <= lanes_i;
      wdata_ff  <= wdata_i;
      narrow_ff <= narrow_bus_i;
      // strap low forces address; else disable bits decide
      if (!strap_n) begin
        addr_on_bus_ff <= 1'b1;
      end else begin
        addr_on_bus_ff <= !((low_region_i && low_region_select_config_disable_address_bit_i)
                          || (up_region_i && upper_region_select_config_disable_address_bit_i));
      end
    end
  end

  // ---------------------------------------------------------------
  // pin outputs, all registered, decoded from next and current state
  // ---------------------------------------------------------------
  logic        busy_n;
  logic        refresh;
  logic [15:0] t1_addr;
  assign busy_n  = (nxt_state == EBC_IDLE) || (nxt_state == EBC_HOLD);
  assign refresh = (kind_ff == EBC_KIND_RFSH);
  // refresh: bit0 high on muxed bus; live request, latches load on the same edge
  assign t1_addr = {addr_i[15:1], addr_i[0] | (kind_i == EBC_KIND_RFSH)};

  // muxed bus: address in t1, data t2..t4 on writes, else float
  always_ff @(posedge clk_i) begin
    if (rst_i || nxt_state == EBC_HOLD) begin
      muxed_addr_data_bus_o    <= DATA_RST;
      muxed_addr_data_bus_oe_o <= 16'h0000;
    end else if (nxt_state == EBC_T1 && state_ff == EBC_IDLE) begin
      muxed_addr_data_bus_o    <= t1_addr;
      muxed_addr_data_bus_oe_o <= addr_on_bus_next() ? 16'hffff : 16'h0000;
    end else if (!busy_n && state_ff != EBC_IDLE) begin
      muxed_addr_data_bus_o    <= wdata_ff;
      muxed_addr_data_bus_oe_o <= write_ff ? {{8{lanes_ff[1]}}, {8{lanes_ff[0]}}}
                                           : 16'h0000;
    end else begin
      muxed_addr_data_bus_oe_o <= 16'h0000;
    end
  end

  // decision for the address phase taken from live inputs at t1 entry
  function automatic logic addr_on_bus_next();
    if (!strap_n) begin
      return 1'b1;
    end
    return !((low_region_i && low_region_select_config_disable_address_bit_i)
          || (up_region_i && upper_region_select_config_disable_address_bit_i));
  endfunction

  // high address outputs on the narrow variant, every state of a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || nxt_state == EBC_HOLD) begin
      high_address_outputs_o    <= 8'h00;
      high_address_outputs_oe_o <= 1'b0;
    end else if (nxt_state == EBC_T1 && state_ff == EBC_IDLE) begin
      high_address_outputs_o    <= addr_i[15:8];
      high_address_outputs_oe_o <= narrow_bus_i;
    end else if (busy_n) begin
      high_address_outputs_oe_o <= 1'b0;
    end
  end

  // plain address: set on the edge into t1, the same edge that puts the address on ad
  always_ff @(posedge clk_i) begin
    if (rst_i || nxt_state == EBC_HOLD) begin
      nonmuxed_address_bus_o    <= ADDR_RST;
      nonmuxed_address_bus_oe_o <= 1'b0;
    end else begin
      nonmuxed_address_bus_oe_o <= 1'b1;
      if (state_ff == EBC_IDLE && nxt_state == EBC_T1) begin
        nonmuxed_address_bus_o <= addr_i;
      end
    end
  end

  // address strobe high during t1 only; falls with address still valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_strobe_o <= 1'b0;
    end else begin
      addr_strobe_o <= (nxt_state == EBC_T1);
    end
  end

  // high-byte enable: unlatched, t1 through t3 and waits
  always_ff @(posedge clk_i) begin
    if (rst_i || nxt_state == EBC_HOLD) begin
      byte_high_en_n_o  <= 1'b1;
      byte_high_en_oe_o <= 1'b0;
    end else begin
      byte_high_en_oe_o <= 1'b1;
      unique case (nxt_state)
        EBC_T1:  byte_high_en_n_o <= (state_ff == EBC_IDLE)
                   ? !(lanes_i[1] && kind_i != EBC_KIND_RFSH) : byte_high_en_n_o;
        EBC_T2, EBC_T3, EBC_TW: byte_high_en_n_o <= byte_high_en_n_o;
        default: byte_high_en_n_o <= 1'b1;
      endcase
    end
  end

  // per-lane write strobes t2, t3 and waits of writes, released for t4
  always_ff @(posedge clk_i) begin
    if (rst_i || nxt_state == EBC_HOLD) begin
      wr_high_n_o    <= 1'b1;
      wr_low_n_o     <= 1'b1;
      wr_strobe_oe_o <= 1'b0;
    end else begin
      wr_strobe_oe_o <= 1'b1;
      wr_high_n_o    <= !(write_ff && lanes_ff[1] && !busy_n && state_ff != EBC_IDLE
                          && nxt_state != EBC_T4);
      wr_low_n_o     <= !(write_ff && lanes_ff[0] && !busy_n && state_ff != EBC_IDLE
                          && nxt_state != EBC_T4);
    end
  end

  // direction: high to transmit; transceiver enable off across any turn
  always_ff @(posedge clk_i) begin
    if (rst_i || nxt_state == EBC_HOLD) begin
      dir_ff                  <= 1'b0;
      transfer_direction_o    <= 1'b0;
      transfer_direction_oe_o <= 1'b0;
      xcvr_en_n_o             <= 1'b1;
      xcvr_en_oe_o            <= 1'b0;
    end else begin
      transfer_direction_oe_o <= 1'b1;
      xcvr_en_oe_o            <= 1'b1;
      if (state_ff == EBC_T1) begin
        dir_ff               <= write_ff;
        transfer_direction_o <= write_ff;
      end
      xcvr_en_n_o <= !(!busy_n && state_ff != EBC_IDLE && state_ff != EBC_T1
                       && !refresh && dir_ff == write_ff);
    end
  end

  // chip selects high while held, done pulse and read capture at t4
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_sel_n_o <= 1'b1;
      hold_ack_o   <= 1'b0;
      done_o       <= 1'b0;
      rdata_o      <= DATA_RST;
    end else begin
      hold_ack_o   <= (nxt_state == EBC_HOLD);
      chip_sel_n_o <= (nxt_state == EBC_HOLD) ? 1'b1 : chip_sel_n_i;
      done_o       <= (state_ff == EBC_T4);
      if (state_ff == EBC_T4 && !write_ff) begin
        rdata_o <= muxed_addr_data_bus_i;
      end
    end
  end
endmodule

// File: verif/ebc_partner.sv
// ebc_partner: far-side memory and external hold master
// assumes: bench sets read data, wait count, ready style and hold wish
`timescale 1ns/1ps
module ebc_partner (
  input  wire logic        clk_i,
  input  wire logic        addr_strobe_i,
  input  wire logic        done_i,
  input  wire logic        hold_ack_i,
  input  wire logic [15:0] bus_o_i,
  input  wire logic [15:0] bus_oe_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic [3:0]  waits_i,
  input  wire logic        use_sync_i,
  input  wire logic        hold_want_i,
  output logic             async_ready_o,
  output logic             sync_ready_o,
  output logic             hold_req_o,
  output logic [15:0]      bus_i_o
);
  logic        busy_ff = 1'b0;
  logic        ack_ff = 1'b0;
  logic        block_ff = 1'b0;
  logic [3:0]  cnt_ff = 4'h0;
  logic [15:0] last_ff = 16'h0000;
  logic        rdy;

  // cycle tracker: counts data-phase clocks for the slave's waits
  always_ff @(posedge clk_i) begin
    if (addr_strobe_i) busy_ff <= 1'b1;
    else if (done_i) busy_ff <= 1'b0;
    if (addr_strobe_i) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
    last_ff <= bus_i_o;
  end

  // ready: async style high when no waits or waits counted; sync style holds async low and uses sync ready
  assign rdy = busy_ff && (cnt_ff >= waits_i);
  assign async_ready_o = !use_sync_i && (waits_i == 4'h0 || rdy);
  assign sync_ready_o = use_sync_i && rdy;
  // wire level: device drives where enabled, slave data in cycle, else toggling
  assign bus_i_o = (bus_o_i & bus_oe_i) | (~bus_oe_i & (busy_ff ? rd_data_i : ~last_ff));

  // hold master: asks while wanted, yields when the device reclaims
  always_ff @(posedge clk_i) begin
    ack_ff <= hold_ack_i;
    if (!hold_want_i) block_ff <= 1'b0;
    else if (ack_ff && !hold_ack_i) block_ff <= 1'b1;
  end
  assign hold_req_o = hold_want_i && !block_ff;
endmodule

// File: verif/ebc_top_asserts.sv
// ebc_top_asserts: port-level checks of bus cycles and the hold handshake
// assumes: bound to ebc_top; one clock, synchronous active-high reset
`timescale 1ns/1ps
module ebc_top_asserts
  import ebc_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         req_i,
  input wire ebc_kind_type kind_i,
  input wire logic         narrow_bus_i,
  input wire logic         hold_req_i,
  input wire logic         addr_strobe_o,
  input wire logic         done_o,
  input wire logic [15:0]  muxed_addr_data_bus_o,
  input wire logic [15:0]  muxed_addr_data_bus_oe_o,
  input wire logic         high_address_outputs_oe_o,
  input wire logic         nonmuxed_address_bus_oe_o,
  input wire logic         byte_high_en_n_o,
  input wire logic         byte_high_en_oe_o,
  input wire logic         wr_low_n_o,
  input wire logic         wr_strobe_oe_o,
  input wire logic         xcvr_en_oe_o,
  input wire logic         transfer_direction_o,
  input wire logic         transfer_direction_oe_o,
  input wire logic         chip_sel_n_o,
  input wire logic         hold_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // any bus pin enabled
  wire any_oe = (|muxed_addr_data_bus_oe_o) | high_address_outputs_oe_o
    | nonmuxed_address_bus_oe_o | byte_high_en_oe_o | wr_strobe_oe_o | xcvr_en_oe_o
    | transfer_direction_oe_o;

  // cycle steps: address state, then t2..t4, then completion
  sequence s_addr; addr_strobe_o; endsequence
  sequence s_body; (!done_o) [*4] ##[1:40] done_o; endsequence

  // longest hold latency with no wait states, in clocks
  localparam int LAT_MAX = HOLD_MAX_CYC;

  property p_strobe; s_addr |=> !addr_strobe_o; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not one cycle");
  property p_cycle; s_addr |-> s_body; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle length wrong");
  property p_rfsh;
    s_addr and (req_i && kind_i == EBC_KIND_RFSH) |->
      byte_high_en_n_o && muxed_addr_data_bus_o[0];
  endproperty
  a_rfsh: assert property (p_rfsh) else $error("refresh code wrong");
  property p_float; hold_ack_o |-> !any_oe; endproperty
  a_float: assert property (p_float)
    else $error("bus driven in hold");
  property p_cs; hold_ack_o |-> chip_sel_n_o; endproperty
  a_cs: assert property (p_cs) else $error("select low in hold");
  property p_rst; $fell(rst_i) |-> !any_oe && !hold_ack_o && !done_o; endproperty
  a_rst: assert property (p_rst) else $error("bus driven in reset");
  property p_dir; !wr_low_n_o && wr_strobe_oe_o |-> transfer_direction_o && transfer_direction_oe_o;
  endproperty
  a_dir: assert property (p_dir) else $error("write without transmit");
  property p_rel; hold_ack_o && !hold_req_i |-> ##[1:4] !hold_ack_o; endproperty
  a_rel: assert property (p_rel) else $error("grant kept after release");
  property p_narrow;
    s_addr and (narrow_bus_i && !hold_ack_o) |-> high_address_outputs_oe_o [*4];
  endproperty
  a_narrow: assert property (p_narrow) else $error("high address not held");
  property p_lat; $rose(hold_req_i) |-> ##[1:LAT_MAX] hold_ack_o; endproperty
  a_lat: assert property (p_lat) else $error("hold grant too late");
endmodule

// File: verif/ebc_top_tb.sv
// ebc_top_tb: self-checking bench for the external bus cycle block
// assumes: ebc_partner answers on the far side; checker bound below
`timescale 1ns/1ps
module ebc_top_tb
  import ebc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, req_i = 0, write_i = 0, low_region_i = 0, up_region_i = 0;
  logic lo_dis = 0, up_dis = 0, narrow_bus_i = 0, chip_sel_n_i = 1, strap_n = 1, strap_cap;
  logic use_sync = 0, hold_want = 0, done_o, strb, hbe_n, hbe_oe, whn, wln, wr_oe, xen, xen_oe;
  logic dir, dir_oe, cs_n, hack, hao_oe, nmx_oe, async_rdy, sync_rdy, hold_req;
  ebc_kind_type kind_i = EBC_KIND_MEM;
  logic [1:0]   lanes_i = 2'h3;
  logic [3:0]   waits = 4'h0;
  logic [7:0]   hao;
  logic [15:0]  wdata_i = 16'h0000, rd_data = 16'h0000, rdata_o, bus_o, bus_oe, bus_in;
  logic [19:0]  addr_i = 20'h00000, nmx;
  int           failures = 0, total_checks = 0, cyc = 0;

  ebc_top i_ebc_top (.clk_i, .rst_i, .req_i, .kind_i, .write_i, .addr_i, .lanes_i, .wdata_i,
    .low_region_i, .up_region_i, .low_region_select_config_disable_address_bit_i(lo_dis),
    .upper_region_select_config_disable_address_bit_i(up_dis), .narrow_bus_i, .chip_sel_n_i,
    .done_o, .rdata_o, .async_ready_i(async_rdy), .sync_ready_i(sync_rdy), .hold_req_i(hold_req),
    .addr_enable_strap_n_i(strap_n), .muxed_addr_data_bus_i(bus_in), .muxed_addr_data_bus_o(bus_o),
    .muxed_addr_data_bus_oe_o(bus_oe), .high_address_outputs_o(hao),
    .high_address_outputs_oe_o(hao_oe), .nonmuxed_address_bus_o(nmx),
    .nonmuxed_address_bus_oe_o(nmx_oe), .addr_strobe_o(strb), .byte_high_en_n_o(hbe_n),
    .byte_high_en_oe_o(hbe_oe), .wr_high_n_o(whn), .wr_low_n_o(wln), .wr_strobe_oe_o(wr_oe),
    .xcvr_en_n_o(xen), .xcvr_en_oe_o(xen_oe), .transfer_direction_o(dir),
    .transfer_direction_oe_o(dir_oe), .chip_sel_n_o(cs_n), .hold_ack_o(hack));

  ebc_partner i_ebc_partner (.clk_i, .addr_strobe_i(strb), .done_i(done_o), .hold_ack_i(hack),
    .bus_o_i(bus_o), .bus_oe_i(bus_oe), .rd_data_i(rd_data), .waits_i(waits),
    .use_sync_i(use_sync), .hold_want_i(hold_want), .async_ready_o(async_rdy),
    .sync_ready_o(sync_rdy), .hold_req_o(hold_req), .bus_i_o(bus_in));

  // 20 MHz clock
  initial forever #25 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one core request, checked state by state against the model
  task automatic bus_cycle(input ebc_kind_type k, input logic [1:0] ln);
    logic [19:0] a;
    logic [15:0] d, ma, m;
    logic        wr, aoe;
    a = 20'($urandom);
    a[0] = (ln == 2'h2);
    d = 16'($urandom);
    wr = (k < EBC_KIND_INTA) && ($urandom_range(0, 1) == 1);
    @(posedge clk_i);
    kind_i <= k;
    write_i <= wr;
    addr_i <= a;
    lanes_i <= ln;
    wdata_i <= d;
    rd_data <= ~d;
    {low_region_i, up_region_i, lo_dis, up_dis, narrow_bus_i, chip_sel_n_i, use_sync}
      <= 7'($urandom);
    waits <= 4'($urandom_range(0, 3));
    req_i <= 1'b1;
    @(negedge clk_i);
    while (!strb) @(negedge clk_i);
    ma = {{8{!narrow_bus_i}}, 8'hff};
    m = ma & {{8{ln[1]}}, {8{ln[0]}}};
    aoe = !strap_cap || !(low_region_i && lo_dis || up_region_i && up_dis);
    chk(nmx, a);
    chk(hbe_n, k == EBC_KIND_RFSH || !ln[1]);
    chk(hao_oe, narrow_bus_i);
    if (narrow_bus_i) chk(hao, a[15:8]);
    if (k != EBC_KIND_RFSH) chk(|bus_oe, aoe);
    if (k != EBC_KIND_RFSH && aoe) chk(bus_o & ma, a[15:0] & ma);
    // request is latched at t1 entry; dropping it now stops a second take at idle
    @(posedge clk_i);
    req_i <= 1'b0;
    @(negedge clk_i);
    if (k != EBC_KIND_RFSH) chk(dir, wr);
    if (wr) chk(bus_o & m, d & m);
    if (wr) chk({whn, wln}, 2'(~ln));
    @(negedge clk_i);
    chk(xen, k == EBC_KIND_RFSH);
    while (!done_o) @(negedge clk_i);
    if (!wr && k != EBC_KIND_RFSH) chk(rdata_o & m, ~d & m);
  endtask

  // grant, refusal while held, then release or refresh reclaim
  task automatic hold_test(input ebc_kind_type k);
    @(posedge clk_i);
    hold_want <= 1'b1;
    @(negedge clk_i);
    while (!hack) @(negedge clk_i);
    chk(cs_n, 1'b1);
    chk({|bus_oe, hao_oe, nmx_oe}, 3'h0);
    chk({hbe_oe, wr_oe}, 2'h0);
    chk({xen_oe, dir_oe}, 2'h0);
    fork
      bus_cycle(k, 2'h3);
      if (k != EBC_KIND_RFSH) begin
        repeat (8) begin
          @(negedge clk_i);
          chk(strb, 1'b0);
        end
        @(posedge clk_i);
        hold_want <= 1'b0;
      end
    join
    @(posedge clk_i);
    hold_want <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(hack, 1'b0);
  endtask

  // verdict
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // main sequence: both strap levels, all cycle kinds, then hold
  initial begin
    void'($urandom(5));
    for (int s = 1; s >= 0; s--) begin
      if (s == 0) @(posedge clk_i);
      rst_i <= 1'b1;
      strap_n <= s[0];
      strap_cap = s[0];
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      strap_n <= !s[0];
      for (int i = 0; i < 16; i++) bus_cycle(ebc_kind_type'(i % 4), 2'h3 - 2'(i % 3));
      $display("test strap=%0d cycles finished", s);
    end
    hold_test(EBC_KIND_MEM);
    $display("test hold release finished");
    hold_test(EBC_KIND_RFSH);
    $display("test refresh reclaim finished");
    finish_test();
  end
endmodule

bind ebc_top ebc_top_asserts i_ebc_top_asserts (.clk_i, .rst_i, .req_i, .kind_i, .narrow_bus_i,
  .hold_req_i, .addr_strobe_o, .done_o, .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe_o,
  .high_address_outputs_oe_o, .nonmuxed_address_bus_oe_o, .byte_high_en_n_o, .byte_high_en_oe_o,
  .wr_low_n_o, .wr_strobe_oe_o, .xcvr_en_oe_o, .transfer_direction_o, .transfer_direction_oe_o,
  .chip_sel_n_o, .hold_ack_o);
